// file: shared/lsu_pkg.sv
// Shared constants and types for the load/store byte-lane datapath
package lsu_pkg;

   // ************************************************
   // Access-size codes (bytes accessed minus one)
   // ************************************************
   localparam logic [2:0] SZ_BYTE = 3'h0;
   localparam logic [2:0] SZ_HALF = 3'h1;
   localparam logic [2:0] SZ_WORD = 3'h3;
   localparam logic [2:0] SZ_DOUBLE = 3'h7;

   // ************************************************
   // Values after reset and fixed counts
   // ************************************************
   localparam logic RST_READY = 1'h1;
   localparam logic [63:0] RST_DATA = 64'h0;
   localparam logic [4:0] ZERO_REG = 5'h0;
   localparam int LOAD_DELAY_CYCLES = 1;

   // ************************************************
   // Load and store operations from instruction decode
   // ************************************************
   typedef enum logic [4:0] {
      load_byte_signed,
      load_byte_zero_ext,
      load_half_signed,
      load_half_zero_ext,
      load_word_signed,
      load_word_zero_ext,
      load_word_left_merge,
      load_word_right_merge,
      load_double,
      load_double_left_merge,
      load_double_right_merge,
      store_byte,
      store_half,
      store_word,
      store_word_left_part,
      store_word_right_part,
      store_double,
      store_double_left_part,
      store_double_right_part
   } op_t;

endpackage

// file: verilog/lane_mask_decode.sv
// Byte-lane mask and legality check for one doubleword access
`timescale 1ns/1ps
`default_nettype none
module lane_mask_decode (
   // Access shape
   input wire logic [2:0] size_i,
   input wire logic [2:0] lo_i,
   // Result
   output logic [7:0] lane_o,
   output logic legal_o
);
   import lsu_pkg::*;

   logic [7:0] span; // Contiguous run of size_i+1 lanes from lane 0

   // Lanes start at the addressed low-order byte and run upward
   always_comb begin
      span = 8'hFF >> (3'h7 - size_i);
      lane_o = span << lo_i;
      // Only the tabulated size/offset pairs are legal
      case (size_i)
         3'h7: legal_o = (lo_i == 3'h0);
         3'h6: legal_o = (lo_i[2:1] == 2'h0);
         3'h5: legal_o = (lo_i == 3'h0) || (lo_i == 3'h2);
         3'h4: legal_o = (lo_i == 3'h0) || (lo_i == 3'h3);
         3'h3: legal_o = (lo_i[1:0] == 2'h0);
         3'h2: legal_o = (lo_i[1] == 1'h0);
         3'h1: legal_o = (lo_i[0] == 1'h0);
         default: legal_o = 1'h1;
      endcase
   end
endmodule
`default_nettype wire

// file: verilog/load_store_align.sv
// Load/store address, byte-lane, extension and merge datapath
//
// What this block does
// - Address is base plus sign-extended offset
// - Address names the field's lowest-order byte
// - Little-endian: byte zero in bits 7:0
// - Size code from opcode: 0 byte, 7 doubleword
// - Lanes from size and address; else error
// - Signed byte load sign-extends to 64 bits
// - Unsigned byte load zero-extends to 64 bits
// - Signed halfword load sign-extends
// - Signed word load; sign-extended in 64-bit mode
// - Word-left load shifts up, then merges
// - Word-right load shifts down, then merges
// - Byte store writes low register byte
// - Halfword store writes low 16 bits
// - Word store writes low 32 bits
// - Word-left store shifts right, covered lanes
// - Doubleword load reads all 64 bits
// - Doubleword-left load shifts up, then merges
// - Doubleword-right load shifts down, then merges
// - Doubleword store writes all 64 bits
// - Doubleword-left store shifts right, covered lanes
// - Interlock dependent instruction after a load
`timescale 1ns/1ps
`default_nettype none
module load_store_align (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Issue side from decode and register file
   input wire logic req_valid_i,
   input wire lsu_pkg::op_t req_op_i,
   input wire logic [63:0] base_i,
   input wire logic [15:0] offset_i,
   input wire logic [63:0] target_i,
   input wire logic [4:0] dest_i,
   input wire logic mode64_i,
   input wire logic [4:0] next_src_a_i,
   input wire logic [4:0] next_src_b_i,
   output logic req_ready_o,
   output logic stall_o,
   output logic addr_err_o,
   // Data cache side
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [63:0] mem_addr_o,
   output logic [7:0] mem_lane_o,
   output logic [63:0] mem_wdata_o,
   input wire logic mem_rvalid_i,
   input wire logic [63:0] mem_rdata_i,
   // Register write-back
   output logic wb_valid_o,
   output logic [4:0] wb_reg_o,
   output logic [63:0] wb_data_o
);
   import lsu_pkg::*;

   // ************************************************
   // State
   // ************************************************
   typedef enum logic {
      ph_idle,
      ph_wait_load
   } phase_t;

   typedef struct packed {
      phase_t phase;          // Waiting for load data or not
      logic ready;            // Issue side may present a request
      logic stall;            // Dependent instruction held back
      logic addr_err;         // Address error pulse
      logic mem_req;          // Cache request pulse
      logic mem_we;           // Request is a store
      logic [63:0] mem_addr;  // Virtual address of the access
      logic [7:0] mem_lane;   // Byte lanes touched
      logic [63:0] mem_wdata; // Store data on its lanes
      op_t ld_op;             // Pending load kind
      logic [2:0] ld_lo;      // Pending load low address bits
      logic [63:0] ld_old;    // Target contents for merges
      logic ld_m64;           // Pending load in 64-bit mode
      logic [4:0] ld_dest;    // Pending load destination
      logic wb_valid;         // Write-back pulse
      logic [4:0] wb_reg;     // Write-back register
      logic [63:0] wb_data;   // Write-back value
   } state_t;

   state_t st;      // Registered state
   state_t next_st; // Next state

   // ************************************************
   // Issue-side decode signals
   // ************************************************
   logic accept;        // Request taken this cycle
   logic [63:0] vaddr;  // Effective virtual address
   logic [2:0] lo;      // Low address bits
   logic [1:0] kw;      // Byte within word
   logic [2:0] size;    // Access-size code
   logic [2:0] start;   // First lane touched
   logic is_store;      // Operation writes memory
   logic [7:0] lane;    // Lanes from the decoder
   logic legal;         // Pairing is permitted
   logic [63:0] wdata;  // Store data aligned to lanes
   logic hazard;        // Next instruction reads the load target

   // ************************************************
   // Load-return signals
   // ************************************************
   logic [63:0] rsh;    // Read data shifted down to lane 0
   logic [31:0] rword;  // Addressed word of the read data
   logic [31:0] wsh;    // Word shifted for a partial merge
   logic [3:0] wmask;   // Word bytes taken from memory
   logic [63:0] wbits;  // Word byte mask widened to bits, low half used
   logic [31:0] wmrg;   // Merged word
   logic [63:0] dsh;    // Doubleword shifted for a merge
   logic [7:0] dmask;   // Doubleword bytes taken from memory
   logic [63:0] ldata;  // Final load value

   // Expand a byte mask to a bit mask
   function automatic logic [63:0] expand(input logic [7:0] m);
      logic [63:0] r;
      r = 64'h0;
      for (int i = 0; i < 8; i++) begin
         r[8*i +: 8] = {8{m[i]}};
      end
      return r;
   endfunction

   // ************************************************
   // Lane decode
   // ************************************************
   lane_mask_decode u_lane (
      .size_i(size),
      .lo_i(start),
      .lane_o(lane),
      .legal_o(legal)
   );

   // Address, size and store alignment for the presented request
   always_comb begin
      accept = req_valid_i && st.ready;
      vaddr = base_i + {{48{offset_i[15]}}, offset_i};
      lo = vaddr[2:0];
      kw = vaddr[1:0];
      is_store = 1'h1;
      size = SZ_BYTE;
      start = lo;
      wdata = target_i << {lo, 3'h0};
      case (req_op_i)
         load_byte_signed, load_byte_zero_ext: begin
            is_store = 1'h0;
            size = SZ_BYTE;
         end
         load_half_signed, load_half_zero_ext: begin
            is_store = 1'h0;
            size = SZ_HALF;
         end
         load_word_signed, load_word_zero_ext: begin
            is_store = 1'h0;
            size = SZ_WORD;
         end
         load_double: begin
            is_store = 1'h0;
            size = SZ_DOUBLE;
         end
         // Partial word: lanes from word base up to the address
         load_word_left_merge: begin
            is_store = 1'h0;
            size = {1'h0, kw};
            start = {lo[2], 2'h0};
         end
         // Partial word: lanes from the address to word end
         load_word_right_merge: begin
            is_store = 1'h0;
            size = {1'h0, ~kw};
         end
         load_double_left_merge: begin
            is_store = 1'h0;
            size = lo;
            start = 3'h0;
         end
         load_double_right_merge: begin
            is_store = 1'h0;
            size = ~lo;
         end
         store_byte: size = SZ_BYTE;
         store_half: size = SZ_HALF;
         store_word: size = SZ_WORD;
         store_double: size = SZ_DOUBLE;
         store_word_left_part: begin
            size = {1'h0, kw};
            start = {lo[2], 2'h0};
            wdata = ({32'h0, target_i[31:0]} >> {~kw, 3'h0}) << {lo[2], 5'h0};
         end
         store_word_right_part: begin
            size = {1'h0, ~kw};
            wdata = ({32'h0, target_i[31:0]} << {kw, 3'h0}) << {lo[2], 5'h0};
         end
         store_double_left_part: begin
            size = lo;
            start = 3'h0;
            wdata = target_i >> {~lo, 3'h0};
         end
         store_double_right_part: begin
            size = ~lo;
            wdata = target_i << {lo, 3'h0};
         end
         default: size = SZ_BYTE;
      endcase
      // Register zero never carries a dependence
      hazard = !is_store && (dest_i != ZERO_REG) &&
               ((dest_i == next_src_a_i) || (dest_i == next_src_b_i));
   end

   // ************************************************
   // Load return: extend or merge
   // ************************************************
   always_comb begin
      rsh = mem_rdata_i >> {st.ld_lo, 3'h0};
      rword = st.ld_lo[2] ? mem_rdata_i[63:32] : mem_rdata_i[31:0];
      // Left merge lifts the addressed byte to the top
      if (st.ld_op == load_word_left_merge) begin
         wsh = rword << {~st.ld_lo[1:0], 3'h0};
         wmask = 4'hF << ~st.ld_lo[1:0];
      end else begin
         wsh = rword >> {st.ld_lo[1:0], 3'h0};
         wmask = 4'hF >> st.ld_lo[1:0];
      end
      // A function result cannot be part-selected, so widen into a variable first
      wbits = expand({4'h0, wmask});
      wmrg = (wsh & wbits[31:0]) | (st.ld_old[31:0] & ~wbits[31:0]);
      if (st.ld_op == load_double_left_merge) begin
         dsh = mem_rdata_i << {~st.ld_lo, 3'h0};
         dmask = 8'hFF << ~st.ld_lo;
      end else begin
         dsh = mem_rdata_i >> {st.ld_lo, 3'h0};
         dmask = 8'hFF >> st.ld_lo;
      end
      case (st.ld_op)
         load_byte_signed: ldata = {{56{rsh[7]}}, rsh[7:0]};
         load_byte_zero_ext: ldata = {56'h0, rsh[7:0]};
         load_half_signed: ldata = {{48{rsh[15]}}, rsh[15:0]};
         load_half_zero_ext: ldata = {48'h0, rsh[15:0]};
         load_word_zero_ext: ldata = {32'h0, rsh[31:0]};
         // 32-bit mode leaves the upper half at zero
         load_word_signed: ldata = st.ld_m64 ? {{32{rsh[31]}}, rsh[31:0]} : {32'h0, rsh[31:0]};
         // Partial word merges keep the old upper half in 32-bit mode
         load_word_left_merge, load_word_right_merge:
            ldata = st.ld_m64 ? {{32{wmrg[31]}}, wmrg} : {st.ld_old[63:32], wmrg};
         load_double_left_merge, load_double_right_merge:
            ldata = (dsh & expand(dmask)) | (st.ld_old & ~expand(dmask));
         default: ldata = mem_rdata_i;
      endcase
   end

   // ************************************************
   // Next-state logic
   // ************************************************
   // Pulses drop each cycle; a request reloads addr_err and mem_req, returning load data reloads wb_valid
   always_comb begin
      next_st = st;
      next_st.addr_err = 1'h0;
      next_st.mem_req = 1'h0;
      next_st.wb_valid = 1'h0;
      case (st.phase)
         ph_idle: begin
            if (accept) begin
               next_st.mem_addr = vaddr;
               next_st.mem_lane = lane;
               next_st.mem_we = is_store;
               next_st.mem_wdata = wdata;
               if (!legal) begin
                  // Illegal pairing: no cache access at all
                  next_st.addr_err = 1'h1;
               end else if (is_store) begin
                  next_st.mem_req = 1'h1;
               end else begin
                  next_st.mem_req = 1'h1;
                  next_st.phase = ph_wait_load;
                  next_st.ready = 1'h0;
                  next_st.stall = hazard;
                  next_st.ld_op = req_op_i;
                  next_st.ld_lo = lo;
                  next_st.ld_old = target_i;
                  next_st.ld_m64 = mode64_i;
                  next_st.ld_dest = dest_i;
               end
            end
         end
         ph_wait_load: begin
            // Stall holds until the value reaches write-back
            if (mem_rvalid_i) begin
               next_st.phase = ph_idle;
               next_st.ready = RST_READY;
               next_st.stall = 1'h0;
               next_st.wb_valid = 1'h1;
               next_st.wb_reg = st.ld_dest;
               next_st.wb_data = ldata;
            end
         end
         default: next_st.phase = ph_idle;
      endcase
   end

   // ************************************************
   // State register
   // ************************************************
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
         st.ready <= RST_READY;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************
   // Outputs, all straight from the state register
   // ************************************************
   assign req_ready_o = st.ready;
   assign stall_o = st.stall;
   assign addr_err_o = st.addr_err;
   assign mem_req_o = st.mem_req;
   assign mem_we_o = st.mem_we;
   assign mem_addr_o = st.mem_addr;
   assign mem_lane_o = st.mem_lane;
   assign mem_wdata_o = st.mem_wdata;
   assign wb_valid_o = st.wb_valid;
   assign wb_reg_o = st.wb_reg;
   assign wb_data_o = st.wb_data;

endmodule
`default_nettype wire

// file: verif/lsa_props.sv
// Concurrent checks on the load/store alignment block ports
`timescale 1ns/1ps
`default_nettype none
module lsa_props
   import lsu_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Issue side
   input wire logic req_valid_i,
   input wire lsu_pkg::op_t req_op_i,
   input wire logic [63:0] base_i,
   input wire logic [15:0] offset_i,
   input wire logic [63:0] target_i,
   input wire logic [4:0] dest_i,
   input wire logic [4:0] next_src_a_i,
   input wire logic [4:0] next_src_b_i,
   input wire logic req_ready_o,
   input wire logic stall_o,
   input wire logic addr_err_o,
   // Cache side
   input wire logic mem_req_o,
   input wire logic [63:0] mem_addr_o,
   input wire logic [7:0] mem_lane_o,
   input wire logic [63:0] mem_wdata_o,
   input wire logic mem_rvalid_i,
   input wire logic wb_valid_o
);
   // Accepted request, its address, and whether the next instruction needs it
   wire logic take = req_valid_i && req_ready_o;
   wire logic [63:0] ea = base_i + {{48{offset_i[15]}}, offset_i};
   wire logic is_ld = req_op_i < store_byte;
   wire logic hit = dest_i != ZERO_REG && (next_src_a_i == dest_i || next_src_b_i == dest_i);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // ************************************************
   // Steps of a load
   // ************************************************
   sequence s_ld_issue;
      take && is_ld ##1 mem_req_o;
   endsequence
   sequence s_ld_return;
      mem_rvalid_i && !req_ready_o;
   endsequence
   chk_one_answer: assert property (take |=> mem_req_o != addr_err_o)
      else $error("request not answered exactly once");
   chk_eff_addr: assert property (take |=> mem_addr_o == $past(ea))
      else $error("effective address wrong");
   chk_byte_lane: assert property (take && req_op_i == store_byte |=>
      mem_lane_o == 8'h01 << $past(ea[2:0]) && 8'(mem_wdata_o >> {$past(ea[2:0]), 3'h0}) == $past(target_i[7:0]))
      else $error("byte store lane or data wrong");
   chk_dbl_store: assert property (take && req_op_i == store_double && ea[2:0] == 3'h0 |=>
      mem_lane_o == 8'hFF && mem_wdata_o == $past(target_i))
      else $error("doubleword store wrong");
   chk_word_align: assert property (take && req_op_i == store_word && ea[1:0] != 2'h0 |=> addr_err_o)
      else $error("misaligned word store not refused");
   chk_ld_wait: assert property (s_ld_issue |-> !req_ready_o)
      else $error("ready while load waits");
   chk_ld_return: assert property (s_ld_return |=> wb_valid_o && req_ready_o && !stall_o)
      else $error("load result not one cycle after data");
   chk_stall_set: assert property (take && is_ld && hit |=> stall_o != addr_err_o)
      else $error("dependent instruction not held");
endmodule
bind load_store_align lsa_props u_lsa_props (.mclk_i, .rst_i, .req_valid_i, .req_op_i, .base_i,
   .offset_i, .target_i, .dest_i, .next_src_a_i, .next_src_b_i, .req_ready_o, .stall_o, .addr_err_o,
   .mem_req_o, .mem_addr_o, .mem_lane_o, .mem_wdata_o, .mem_rvalid_i, .wb_valid_o);
`default_nettype wire

// file: verif/cache_model.sv
// Data cache model: eight doublewords, paced read answers
`timescale 1ns/1ps
`default_nettype none
module cache_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Request from the block
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [63:0] mem_addr_i,
   input wire logic [7:0] mem_lane_i,
   input wire logic [63:0] mem_wdata_i,
   // Extra wait cycles before a read answers
   input wire logic [1:0] wait_i,
   // Answer
   output logic mem_rvalid_o,
   output logic [63:0] mem_rdata_o
);
   logic [63:0] mem [8]; // Indexed by address bits 5:3
   logic [2:0] cnt; // Cycles left until a read answers
   logic [2:0] idx; // Doubleword of the pending read
   // Idle read data toggles so a stale value never looks valid
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 3'h0;
         mem_rvalid_o <= 1'h0;
         mem_rdata_o <= 64'h0;
      end else begin
         mem_rvalid_o <= 1'h0;
         mem_rdata_o <= ~mem_rdata_o;
         if (mem_req_i && mem_we_i) begin
            for (int i = 0; i < 8; i++) begin
               if (mem_lane_i[i]) begin
                  mem[mem_addr_i[5:3]][8*i +: 8] <= mem_wdata_i[8*i +: 8];
               end
            end
         end
         if (mem_req_i && !mem_we_i) begin
            cnt <= {1'h0, wait_i} + 3'h1;
            idx <= mem_addr_i[5:3];
         end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
               mem_rvalid_o <= 1'h1;
               mem_rdata_o <= mem[idx];
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: verif/load_store_byte_lane_align_test.sv
// Self-checking bench for the load/store alignment block
`timescale 1ns/1ps
`default_nettype none
module load_store_byte_lane_align_test;
   import lsu_pkg::*;
   // Stimulus and observed signals
   logic mclk_i = 1'h0, rst_i = 1'h1, req_valid_i = 1'h0, mode64_i = 1'h1;
   op_t req_op_i = load_byte_signed;
   logic [63:0] base_i = 64'h2000, target_i = 64'h0;
   logic [15:0] offset_i = 16'h0;
   logic [4:0] dest_i = 5'h5, next_src_a_i = 5'h5, next_src_b_i = 5'h7;
   logic [1:0] wait_i = 2'h0;
   logic req_ready_o, stall_o, addr_err_o, mem_req_o, mem_we_o, mem_rvalid_i, wb_valid_o;
   logic [63:0] mem_addr_o, mem_wdata_o, mem_rdata_i, wb_data_o;
   logic [7:0] mem_lane_o;
   logic [4:0] wb_reg_o;
   int fail_count = 0, tests_run = 0;
   always #5 mclk_i = ~mclk_i;
   load_store_align u_load_store_align (.mclk_i, .rst_i, .req_valid_i, .req_op_i, .base_i, .offset_i,
      .target_i, .dest_i, .mode64_i, .next_src_a_i, .next_src_b_i, .req_ready_o, .stall_o, .addr_err_o,
      .mem_req_o, .mem_we_o, .mem_addr_o, .mem_lane_o, .mem_wdata_o, .mem_rvalid_i, .mem_rdata_i,
      .wb_valid_o, .wb_reg_o, .wb_data_o);
   cache_model u_cache_model (.mclk_i, .rst_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
      .mem_addr_i(mem_addr_o), .mem_lane_i(mem_lane_o), .mem_wdata_i(mem_wdata_o), .wait_i,
      .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));
   task automatic check(input string name, input logic [63:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Request held from a falling edge until the next one, so it stays up back to back
   task automatic issue(input op_t op, input logic [15:0] off, input logic [63:0] tgt);
      req_op_i = op;
      offset_i = off;
      target_i = tgt;
      req_valid_i = 1'h1;
      @(posedge mclk_i);
      @(negedge mclk_i);
   endtask
   // Bit mask of the enabled byte lanes; other lanes carry no meaning
   function automatic logic [63:0] lm(input logic [7:0] l);
      for (int i = 0; i < 8; i++)
         lm[8*i +: 8] = {8{l[i]}};
   endfunction
   task automatic test_stores;
      op_t op[8] = '{store_byte, store_half, store_word, store_double, store_word_left_part,
         store_word_right_part, store_double_left_part, store_double_right_part};
      logic [2:0] k[8] = '{3'h3, 3'h6, 3'h4, 3'h0, 3'h1, 3'h5, 3'h2, 3'h6};
      logic [7:0] ln[8] = '{8'h08, 8'hC0, 8'hF0, 8'hFF, 8'h03, 8'hE0, 8'h07, 8'hC0};
      logic [63:0] d[8] = '{64'h88000000, 64'h7788000000000000, 64'h5566778800000000, 64'h1122334455667788,
         64'h5566, 64'h6677880000000000, 64'h112233, 64'h7788000000000000};
      for (int i = 0; i < 8; i++) begin
         issue(op[i], 16'hFFF0 + 16'(k[i]), 64'h1122334455667788);
         check("store req", {mem_req_o, mem_we_o}, 2'h3);
         check("store addr", mem_addr_o, 64'h1FF0 + 64'(k[i]));
         check("store lanes", mem_lane_o, ln[i]);
         check("store data", mem_wdata_o & lm(ln[i]), d[i]);
      end
      $display("stores done");
   endtask
   task automatic test_errors;
      op_t op[4] = '{store_word, store_half, store_double, load_double};
      logic [2:0] k[4] = '{3'h2, 3'h1, 3'h4, 3'h4};
      for (int i = 0; i < 4; i++) begin
         issue(op[i], 16'hFFF0 + 16'(k[i]), 64'h0);
         check("error flags", {addr_err_o, mem_req_o, req_ready_o}, 3'h5);
         check("error addr", mem_addr_o, 64'h1FF0 + 64'(k[i]));
      end
      $display("errors done");
   endtask
   task automatic test_loads;
      op_t op[12] = '{load_byte_signed, load_byte_zero_ext, load_half_signed, load_half_zero_ext,
         load_word_signed, load_word_signed, load_word_zero_ext, load_double, load_word_left_merge,
         load_word_right_merge, load_double_left_merge, load_double_right_merge};
      logic [2:0] k[12] = '{3'h1, 3'h1, 3'h2, 3'h6, 3'h4, 3'h4, 3'h0, 3'h0, 3'h1, 3'h6, 3'h2, 3'h5};
      logic [63:0] d[12] = '{64'hFFFFFFFFFFFFFFCD, 64'hCD, 64'hFFFFFFFFFFFF89AB, 64'h8123,
         64'hFFFFFFFF81234567, 64'h81234567, 64'h89ABCDEF, 64'h8123456789ABCDEF, 64'hFFFFFFFFCDEFAAAA,
         64'hFFFFFFFFAAAA8123, 64'hABCDEFAAAAAAAAAA, 64'hAAAAAAAAAA812345};
      issue(store_double, 16'hFFF8, 64'h8123456789ABCDEF);
      check("fill", mem_req_o, 1'h1);
      for (int i = 0; i < 12; i++) begin
         mode64_i = (i != 5);
         dest_i = 5'(5 + i % 3);
         wait_i = 2'(i);
         issue(op[i], 16'hFFF8 + 16'(k[i]), 64'hAAAAAAAAAAAAAAAA);
         req_valid_i = 1'h0;
         check("load wait", {mem_req_o, mem_we_o, req_ready_o, stall_o}, {3'h4, i % 3 != 1});
         for (int n = 0; n < 12 && wb_valid_o !== 1'h1; n++)
            @(negedge mclk_i);
         check("load back", {wb_valid_o, stall_o, req_ready_o, wb_reg_o}, {3'h5, dest_i});
         check("load data", wb_data_o, d[i]);
      end
      $display("loads done");
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge mclk_i);
      rst_i = 1'h0;
      test_stores();
      test_errors();
      test_loads();
      stop_test();
   end
   // Watchdog: the whole run needs about 80 cycles
   initial begin
      repeat (3000) @(posedge mclk_i);
      fail_count++;
      stop_test();
   end
endmodule
`default_nettype wire
